// >>> satctl_pkg.sv
// Purpose: shared constants and carriers for the saturation control block
// Assumes: 32-bit APB data, one aligned word per register
// Notes: status register 3 holds only the three saturation enables here
package satctl_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_SR3 = 8'h00;
    localparam logic [7:0] OFF_SETB = 8'h04;
    localparam logic [7:0] OFF_CLRB = 8'h08;
    localparam logic [7:0] OFF_MODE = 8'h0C;
    localparam logic [7:0] OFF_OPA = 8'h10;
    localparam logic [7:0] OFF_OPB = 8'h14;
    localparam logic [7:0] OFF_ACCL = 8'h18;
    localparam logic [7:0] OFF_ACCH = 8'h1C;
    localparam logic [7:0] OFF_CMD = 8'h20;
    localparam logic [7:0] OFF_ALURES = 8'h24;
    localparam logic [7:0] OFF_STRES = 8'h28;
    localparam logic [7:0] OFF_FLAGS = 8'h2C;
    // Status register 3 bit positions and reset
    localparam int BIT_A_SAT = 5;
    localparam int BIT_MUL_SAT = 1;
    localparam int BIT_ST_SAT = 0;
    localparam logic [15:0] SR3_MASK = 16'h0023;
    localparam logic [15:0] SR3_RESET = 16'h0000;
    // Mode register bit positions
    localparam int MODE_FRAC = 0;
    localparam int MODE_D_SAT = 1;
    localparam int MODE_WIDE = 2;
    localparam int MODE_LEGACY = 3;
    localparam int MODE_SIGN_EXT = 4;
    localparam logic [4:0] MODE_RESET = 5'h00;
    // Saturation limits
    localparam logic [15:0] POS16 = 16'h7FFF;
    localparam logic [15:0] NEG16 = 16'h8000;
    localparam logic [31:0] POS32 = 32'h7FFF_FFFF;
    localparam logic [31:0] NEG32 = 32'h8000_0000;
    localparam logic [39:0] POS32_40 = 40'h00_7FFF_FFFF;
    localparam logic [39:0] NEG32_40 = 40'hFF_8000_0000;
    localparam logic [39:0] ACC_RESET = 40'h00_0000_0000;
    typedef enum logic [2:0] {
        OP_ADD, OP_SUB, OP_MPY, OP_MAC, OP_MSU, OP_STORE
    } op_t;
    // Command word: shift[7:4], encoding saturate[3], op[2:0]
    typedef struct packed {
        logic [3:0] shift;
        logic sat_enc;
        op_t op;
    } cmd_t;
    typedef struct packed {
        logic sign_extension_mode;
        logic legacy_compat_mode;
        logic wide_accumulator_mode;
        logic d_unit_saturate_enable;
        logic fractional_mode;
    } mode_t;
endpackage

// >>> mul_sat_unit.sv
// Purpose: signed 16x16 multiply with fractional shift and product clamp
// Assumes: operands are signed 16-bit words
// Notes: purely combinational
`timescale 1ns/100ps
`default_nettype none
module mul_sat_unit
    import satctl_pkg::*;
(
    input wire logic [15:0] a,
    input wire logic [15:0] b,
    input wire logic multiply_saturate_enable,
    input wire satctl_pkg::mode_t mode,
    output logic [39:0] prod,
    output logic sat_hit
);
    logic signed [31:0] raw;
    logic [39:0] ext;
    logic [39:0] shf;
    // Only min times min can overflow the fractional product
    assign raw = $signed(a) * $signed(b);
    assign ext = {{8{raw[31]}}, raw};
    assign shf = mode.fractional_mode ? {ext[38:0], 1'b0} : ext;
    assign sat_hit = multiply_saturate_enable && mode.fractional_mode &&
                     mode.d_unit_saturate_enable && (a == NEG16) && (b == NEG16);
    assign prod = sat_hit ? POS32_40 : shf;
endmodule
`default_nettype wire

// >>> store_clamp_unit.sv
// Purpose: shift and clamp a 40-bit accumulator to a 32-bit store value
// Assumes: left shift only, 0 to 15 places
// Notes: clamp is applied to the shifted value
`timescale 1ns/100ps
`default_nettype none
module store_clamp_unit
    import satctl_pkg::*;
(
    input wire logic [39:0] acc,
    input wire logic [3:0] shift,
    input wire logic sign_extension_mode,
    input wire logic sat_en,
    output logic [31:0] val,
    output logic clamped
);
    logic [39:0] shd;
    logic over;
    logic under;
    // Shift first so the clamp sees the shifted value
    assign shd = acc << shift;
    // Unsigned view flags any value past the positive limit
    assign over = sign_extension_mode ? (!shd[39] && (shd > POS32_40))
                                      : (shd > POS32_40);
    assign under = sign_extension_mode && shd[39] && (shd < NEG32_40);
    assign clamped = sat_en && (over || under);
    assign val = !clamped ? shd[31:0] : (under ? NEG32 : POS32);
endmodule
`default_nettype wire

// >>> sat_mode_ctrl.sv
// Purpose: saturation mode control with test datapath behind an APB slave
// Assumes: APB master holds the request until pready; one wait state
// Notes: writing the command register runs one operation on the held operands
// Notes on behaviour
// - A-unit saturate enable, bit 5, resets 0
// - A-unit overflow clamps to 7FFF or 8000
// - Multiply saturate enable, bit 1, resets 0
// - Min times min fractional gives 7FFFFFFF
// - Multiply-accumulate clamps product before add
// - Store saturate enable, bit 0, legacy only
// - Store clamps 40 to 32 after shift
// - Unsigned store clamp above 7FFFFFFF
// - Signed store clamps both directions
// - Non-legacy stores follow instruction encoding only
// - Each enable set or cleared alone
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module sat_mode_ctrl
    import satctl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import satctl_pkg::*;

    logic [15:0] sr3_r;
    mode_t mode_r;
    logic [15:0] opa_r;
    logic [15:0] opb_r;
    logic [39:0] acc_r;
    logic [15:0] alu_res_r;
    logic [31:0] st_res_r;
    logic [3:0] flags_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;

    // Bus phase decode
    wire take = psel && penable && !pready_r;
    wire fire = psel && penable && pready_r && pwrite;
    wire mapped = (paddr[1:0] == 2'b00) && (paddr <= OFF_FLAGS);
    wire wr_sr3 = fire && (paddr == OFF_SR3);
    wire wr_setb = fire && (paddr == OFF_SETB);
    wire wr_clrb = fire && (paddr == OFF_CLRB);
    wire wr_mode = fire && (paddr == OFF_MODE);
    wire wr_opa = fire && (paddr == OFF_OPA);
    wire wr_opb = fire && (paddr == OFF_OPB);
    wire wr_accl = fire && (paddr == OFF_ACCL);
    wire wr_acch = fire && (paddr == OFF_ACCH);
    wire exec = fire && (paddr == OFF_CMD);
    wire cmd_t cmd = cmd_t'(pwdata[7:0]);

    // Enables seen by the datapath
    wire a_unit_saturate_enable = sr3_r[BIT_A_SAT];
    wire multiply_saturate_enable = sr3_r[BIT_MUL_SAT];
    wire store_saturate_enable = sr3_r[BIT_ST_SAT];

    // A-unit add or subtract on a 17-bit sum to catch overflow
    wire [16:0] alu_b = (cmd.op == OP_SUB) ? -{opb_r[15], opb_r} : {opb_r[15], opb_r};
    wire [16:0] alu_sum = {opa_r[15], opa_r} + alu_b;
    wire alu_ovf = alu_sum[16] != alu_sum[15];
    wire alu_clip = a_unit_saturate_enable && alu_ovf;
    wire [15:0] alu_out = alu_clip ? (alu_sum[16] ? NEG16 : POS16)
                                   : alu_sum[15:0];

    // Product is clamped inside the multiplier, ahead of any accumulate
    logic [39:0] prod;
    logic mul_sat;
    mul_sat_unit u_mul (
        .a(opa_r),
        .b(opb_r),
        .multiply_saturate_enable(multiply_saturate_enable),
        .mode(mode_r),
        .prod(prod),
        .sat_hit(mul_sat)
    );

    // Accumulate after the clamped product; 32-bit wrap guard outside wide mode with D-unit saturate enabled
    wire [39:0] acc_sum = (cmd.op == OP_MSU) ? acc_r - prod : acc_r + prod;
    wire [39:0] acc_pre = (cmd.op == OP_MPY) ? prod : acc_sum;
    wire acc_big = !(acc_pre[39:31] == 9'h000 || acc_pre[39:31] == 9'h1FF);
    wire acc_clip = mode_r.d_unit_saturate_enable && !mode_r.wide_accumulator_mode && acc_big;
    wire [39:0] acc_new = acc_clip ? (acc_pre[39] ? NEG32_40 : POS32_40) : acc_pre;

    // Legacy mode uses the status enable; otherwise the encoding decides
    wire st_sat = mode_r.legacy_compat_mode ? store_saturate_enable : cmd.sat_enc;
    logic [31:0] st_val;
    logic st_clamped;
    store_clamp_unit u_store (
        .acc(acc_r),
        .shift(cmd.shift),
        .sign_extension_mode(mode_r.sign_extension_mode),
        .sat_en(st_sat),
        .val(st_val),
        .clamped(st_clamped)
    );

    // Status register 3: direct write, or per-bit set and clear masks
    wire [15:0] sr3_nxt = wr_sr3 ? (pwdata[15:0] & SR3_MASK)
                        : wr_setb ? (sr3_r | (pwdata[15:0] & SR3_MASK))
                        : wr_clrb ? (sr3_r & ~(pwdata[15:0] & SR3_MASK))
                        : sr3_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sr3_r <= SR3_RESET;
            mode_r <= mode_t'(MODE_RESET);
        end else begin
            sr3_r <= sr3_nxt;
            if (wr_mode) begin
                mode_r <= mode_t'(pwdata[4:0]);
            end
        end
    end

    // Operands and accumulator; a multiply command overrides a same-cycle accumulator write
    wire is_mul = exec && (cmd.op == OP_MPY || cmd.op == OP_MAC || cmd.op == OP_MSU);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opa_r <= 16'h0000;
            opb_r <= 16'h0000;
            acc_r <= ACC_RESET;
        end else begin
            if (wr_opa) opa_r <= pwdata[15:0];
            if (wr_opb) opb_r <= pwdata[15:0];
            if (is_mul) begin
                acc_r <= acc_new;
            end else if (wr_accl) begin
                acc_r <= {acc_r[39:32], pwdata};
            end else if (wr_acch) begin
                acc_r <= {pwdata[7:0], acc_r[31:0]};
            end
        end
    end

    // Results and sticky-free flags of the last command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alu_res_r <= 16'h0000;
            st_res_r <= 32'h0000_0000;
            flags_r <= 4'h0;
        end else if (exec) begin
            if (cmd.op == OP_ADD || cmd.op == OP_SUB) alu_res_r <= alu_out;
            if (cmd.op == OP_STORE) st_res_r <= st_val;
            flags_r <= {acc_clip && is_mul, st_clamped && cmd.op == OP_STORE,
                        mul_sat && is_mul, alu_ovf && cmd.op <= OP_SUB};
        end
    end

    // Read mux
    logic [31:0] rd_mux;
    always_comb begin
        case (paddr)
            OFF_SR3: rd_mux = {16'h0000, sr3_r};
            OFF_MODE: rd_mux = {27'h0, mode_r};
            OFF_OPA: rd_mux = {16'h0000, opa_r};
            OFF_OPB: rd_mux = {16'h0000, opb_r};
            OFF_ACCL: rd_mux = acc_r[31:0];
            OFF_ACCH: rd_mux = {24'h00_0000, acc_r[39:32]};
            OFF_ALURES: rd_mux = {16'h0000, alu_res_r};
            OFF_STRES: rd_mux = st_res_r;
            OFF_FLAGS: rd_mux = {28'h000_0000, flags_r};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // One wait state: answer is latched on the same edge that pready rises
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= take;
            if (take) begin
                prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
                pslverr_r <= !mapped;
            end else if (pready_r) begin
                pslverr_r <= 1'b0;
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire [39:0] shd_chk = acc_r << cmd.shift;

    a_apb_one_wait: assert property (take |=> pready ##1 !pready)
        else $error("pready not one cycle after access start");
    a_sr3_write_rw: assert property (wr_sr3 |=> sr3_r == ($past(pwdata[15:0]) & SR3_MASK))
        else $error("status register write not stored");
    a_alu_pos_clamp: assert property (exec && cmd.op == OP_ADD && alu_clip &&
        !alu_sum[16] |=> alu_res_r == POS16)
        else $error("positive overflow not clamped");
    a_alu_no_sat: assert property (exec && cmd.op <= OP_SUB && !a_unit_saturate_enable
        |=> alu_res_r == $past(alu_sum[15:0]))
        else $error("alu saturated while disabled");
    a_mul_min_sat: assert property (exec && cmd.op == OP_MPY && opa_r == NEG16 &&
        opb_r == NEG16 && multiply_saturate_enable && mode_r.fractional_mode &&
        mode_r.d_unit_saturate_enable |=> acc_r == POS32_40)
        else $error("min product not clamped");
    a_mac_sat_first: assert property (exec && cmd.op == OP_MAC && mul_sat &&
        mode_r.wide_accumulator_mode |=> acc_r == $past(acc_r) + POS32_40)
        else $error("accumulate used unclamped product");
    a_store_unsigned: assert property (exec && cmd.op == OP_STORE &&
        mode_r.legacy_compat_mode && store_saturate_enable && !mode_r.sign_extension_mode &&
        shd_chk > POS32_40 |=> st_res_r == POS32)
        else $error("unsigned store clamp wrong");
    a_store_signed_neg: assert property (exec && cmd.op == OP_STORE &&
        mode_r.legacy_compat_mode && store_saturate_enable && mode_r.sign_extension_mode &&
        shd_chk[39] && shd_chk < NEG32_40 |=> st_res_r == NEG32)
        else $error("signed store low clamp wrong");
    a_store_legacy_off: assert property (exec && cmd.op == OP_STORE &&
        !mode_r.legacy_compat_mode && !cmd.sat_enc |=> st_res_r == $past(shd_chk[31:0]))
        else $error("store saturated without encoding");
    a_bit_set_keep: assert property (wr_setb |=> sr3_r == ($past(sr3_r) |
        ($past(pwdata[15:0]) & SR3_MASK)))
        else $error("bit set disturbed other bits");
    c_alu_clamp: cover property (exec && alu_clip);
    c_mul_clamp: cover property (exec && is_mul && mul_sat);
    c_store_clamp: cover property (exec && cmd.op == OP_STORE && st_clamped);
    // Back-to-back transfers with one idle cycle put two fires four cycles apart
    c_bit_clear: cover property (wr_clrb ##4 wr_setb);
endmodule
`default_nettype wire

// >>> saturation_mode_control_bench.sv
// Purpose: self-checking bench for the saturation control block over APB
// Assumes: one transfer at a time, one idle cycle between transfers
// Notes: expected values come from the saturation limits, not the design
`timescale 1ns/100ps
`default_nettype none
module saturation_mode_control_bench;
    import satctl_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    int err_count = 0;
    int n_tests = 0;
    // 40 MHz clock
    always #12.5 pclk = ~pclk;
    sat_mode_ctrl sat_mode_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One APB transfer; a slave that never answers is caught by the watchdog
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        xfer(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
        logic [31:0] r;
        logic e;
        xfer(1'b0, a, 32'h0000_0000, r, e);
        chk(r, exp);
        chk({31'h0, e}, {31'h0, eexp});
    endtask
    task automatic run(input logic [3:0] sh, input logic enc, input op_t op);
        wr(OFF_CMD, {24'h00_0000, sh, enc, op});
    endtask
    task automatic acc_set(input logic [39:0] v);
        wr(OFF_ACCL, v[31:0]);
        wr(OFF_ACCH, {24'h00_0000, v[39:32]});
    endtask
    task automatic acc_chk(input logic [39:0] v);
        rd(OFF_ACCL, v[31:0], 1'b0);
        rd(OFF_ACCH, {24'h00_0000, v[39:32]}, 1'b0);
    endtask
    task automatic alu(input op_t op, input logic [15:0] a, input logic [15:0] b,
            input logic [15:0] exp);
        wr(OFF_OPA, {16'h0000, a});
        wr(OFF_OPB, {16'h0000, b});
        run(4'h0, 1'b0, op);
        rd(OFF_ALURES, {16'h0000, exp}, 1'b0);
    endtask
    task automatic st(input logic [39:0] v, input logic [3:0] sh, input logic enc,
            input logic [31:0] exp);
        acc_set(v);
        run(sh, enc, OP_STORE);
        rd(OFF_STRES, exp, 1'b0);
    endtask
    // Reset values, then each enable set alone, bit 1 cleared alone, then a direct write and a clear of all three
    task automatic t_bits();
        rd(OFF_SR3, 32'h0000_0000, 1'b0);
        wr(OFF_SETB, 32'h0000_0020);
        rd(OFF_SR3, 32'h0000_0020, 1'b0);
        wr(OFF_SETB, 32'h0000_0002);
        rd(OFF_SR3, 32'h0000_0022, 1'b0);
        wr(OFF_SETB, 32'h0000_0001);
        rd(OFF_SR3, 32'h0000_0023, 1'b0);
        wr(OFF_CLRB, 32'h0000_0002);
        rd(OFF_SR3, 32'h0000_0021, 1'b0);
        wr(OFF_SR3, 32'h0000_FFFF);
        rd(OFF_SR3, 32'h0000_0023, 1'b0);
        wr(OFF_CLRB, 32'h0000_0023);
        rd(OFF_SR3, 32'h0000_0000, 1'b0);
        $display("bits test done");
    endtask
    // Wrap without the enable, clamp with it
    task automatic t_alu();
        alu(OP_ADD, 16'h7FFF, 16'h0001, 16'h8000);
        alu(OP_SUB, 16'h8000, 16'h0001, 16'h7FFF);
        wr(OFF_SETB, 32'h0000_0020);
        alu(OP_ADD, 16'h7FFF, 16'h0001, 16'h7FFF);
        rd(OFF_FLAGS, 32'h0000_0001, 1'b0);
        alu(OP_SUB, 16'h8000, 16'h0001, 16'h8000);
        alu(OP_ADD, 16'h0005, 16'h0003, 16'h0008);
        wr(OFF_CLRB, 32'h0000_0020);
        $display("alu test done");
    endtask
    // Min times min in fractional mode, and the clamp ahead of accumulation
    task automatic t_mul();
        wr(OFF_SETB, 32'h0000_0002);
        wr(OFF_MODE, 32'h0000_0003);
        wr(OFF_OPA, 32'h0000_8000);
        wr(OFF_OPB, 32'h0000_8000);
        run(4'h0, 1'b0, OP_MPY);
        acc_chk(40'h00_7FFF_FFFF);
        rd(OFF_FLAGS, 32'h0000_0002, 1'b0);
        wr(OFF_MODE, 32'h0000_0007);
        run(4'h0, 1'b0, OP_MPY);
        acc_chk(40'h00_7FFF_FFFF);
        acc_set(40'h00_0000_0001);
        run(4'h0, 1'b0, OP_MAC);
        acc_chk(40'h00_8000_0000);
        acc_set(40'h00_0000_0000);
        run(4'h0, 1'b0, OP_MSU);
        acc_chk(40'hFF_8000_0001);
        wr(OFF_CLRB, 32'h0000_0002);
        run(4'h0, 1'b0, OP_MPY);
        acc_chk(40'h00_8000_0000);
        $display("multiply test done");
    endtask
    // Store clamping in both sign modes, legacy and native
    task automatic t_store();
        wr(OFF_MODE, 32'h0000_0008);
        wr(OFF_SETB, 32'h0000_0001);
        st(40'h00_8000_0000, 4'h0, 1'b0, 32'h7FFF_FFFF);
        rd(OFF_FLAGS, 32'h0000_0004, 1'b0);
        st(40'hFF_8000_0000, 4'h0, 1'b0, 32'h7FFF_FFFF);
        st(40'h00_1234_5678, 4'h0, 1'b0, 32'h1234_5678);
        st(40'h00_4000_0000, 4'h1, 1'b0, 32'h7FFF_FFFF);
        wr(OFF_MODE, 32'h0000_0018);
        st(40'hFF_7FFF_FFFF, 4'h0, 1'b0, 32'h8000_0000);
        st(40'h00_8000_0000, 4'h0, 1'b0, 32'h7FFF_FFFF);
        st(40'hFF_8000_0000, 4'h0, 1'b0, 32'h8000_0000);
        st(40'hFF_BFFF_FFFF, 4'h0, 1'b0, 32'hBFFF_FFFF);
        st(40'hFF_BFFF_FFFF, 4'h1, 1'b0, 32'h8000_0000);
        wr(OFF_CLRB, 32'h0000_0001);
        st(40'h00_8000_0000, 4'h0, 1'b1, 32'h8000_0000);
        wr(OFF_MODE, 32'h0000_0010);
        wr(OFF_SETB, 32'h0000_0001);
        st(40'h00_8000_0000, 4'h0, 1'b0, 32'h8000_0000);
        st(40'h00_8000_0000, 4'h0, 1'b1, 32'h7FFF_FFFF);
        $display("store test done");
    endtask
    // Unmapped and unaligned reads are refused
    task automatic t_err();
        rd(8'h30, 32'h0000_0000, 1'b1);
        rd(8'h01, 32'h0000_0000, 1'b1);
        rd(OFF_CMD, 32'h0000_0000, 1'b0);
        $display("error test done");
    endtask
    // Main sequence
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_bits();
        t_alu();
        t_mul();
        t_store();
        t_err();
        give_verdict();
    end
    // Watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        #(25 * 5000);
        err_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
